// ===== pmc_pkg.sv
// Package with the register map, field layout and encodings of the modulation control block.
package pmc_pkg;
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [5:0] IDX_CHAN_SELECT = 6'h00;
	localparam logic [5:0] IDX_GLOBAL_FUNC = 6'h01;
	localparam logic [5:0] IDX_CHAN_FUNC = 6'h03;
	localparam logic [5:0] IDX_FIRST_FREQ = 6'h04;
	localparam logic [5:0] IDX_FIRST_PHASE = 6'h05;
	localparam logic [5:0] IDX_FIRST_AMP = 6'h06;
	localparam logic [5:0] IDX_PROFILE_FIRST = 6'h0A;
	localparam logic [5:0] IDX_PROFILE_LAST = 6'h18;
	// Field positions.
	localparam int CSR_EN_LSB = 0;
	localparam int GF_LEVEL_LSB = 8;
	localparam int GF_RAMP_LSB = 10;
	localparam int GF_PINCFG_LSB = 12;
	localparam int CF_TYPE_LSB = 22;
	localparam int CF_SWEEP_BIT = 14;
	// Word widths.
	localparam int FREQ_W = 32;
	localparam int PHASE_W = 14;
	localparam int AMP_W = 10;
	localparam int NCH = 4;
	// Reset values.
	localparam logic [3:0] CSR_EN_RESET = 4'hF;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	// Modulation type encodings.
	localparam logic [1:0] TYPE_OFF = 2'h0;
	localparam logic [1:0] TYPE_AMP = 2'h1;
	localparam logic [1:0] TYPE_FREQ = 2'h2;
	localparam logic [1:0] TYPE_PHASE = 2'h3;
	// Modulation level encodings.
	localparam logic [1:0] LVL_TWO = 2'h0;
	localparam logic [1:0] LVL_FOUR = 2'h1;
	localparam logic [1:0] LVL_EIGHT = 2'h2;
	localparam logic [1:0] LVL_SIXTEEN = 2'h3;
	// Ramp pin encodings.
	localparam logic [1:0] RAMP_NONE = 2'h0;
	localparam logic [1:0] RAMP_PIN23 = 2'h1;
	localparam logic [1:0] RAMP_PIN3 = 2'h2;
	localparam logic [1:0] RAMP_SDIO = 2'h3;
	// Per-channel output bundle.
	typedef struct packed {
		logic [FREQ_W-1:0] freq;
		logic [PHASE_W-1:0] phase;
		logic [AMP_W-1:0] amp;
		logic ramp_en;
		logic ramp_down;
	} pmc_chan_s;
endpackage

// ===== pmc_top.sv
// Profile pin modulation control with its APB register file.
`timescale 1ns/1ps
// Overview of the block.
// Four channels each carry a frequency, a phase and an amplitude word.
// Software programs word zero of each kind in a dedicated register.
// Software programs fifteen more profile words per channel in a bank.
// Four external profile pins pick which profile word a channel shows.
// The global level field sets how many pins one channel consumes.
// The pin configuration field routes pins to channels in shared modes.
// The ramp field hands one or more pins to the amplitude ramp logic.
// Three serial data lines may instead carry the ramp requests.
// When they do, the serial port must stay in single-bit operation.
// Register access.
// Per-channel registers share one index and are written through enables.
// A write reaches every channel whose enable bit is set in the same edge.
// This lets software program all channels alike with a single write.
// Reads of shared indices show the lowest enabled channel only.
// A limitation: software cannot read back a disabled channel's words.
// Timing.
// Profile and serial pins pass two flops before any logic reads them.
// One output register follows, so pins reach the outputs after three edges.
// Register writes reach the channel outputs one edge after the write lands.
// Every channel and every modulation type sees the same pipeline depth.
// This keeps frequency, phase and amplitude steps aligned in time.
// Unsupported settings.
// Combinations of level, ramp and routing that no table lists are refused.
// A refused combination leaves the affected channels at word zero.
// It also removes the ramp request from those channels, except serial ramp requests at four-level.
// Holding word zero was chosen over guessing a route for a bad setting.
// Software sees no error for such a setting; it must program legal ones.
// Phase and amplitude words sit in the top bits of a profile word.
// The low bits below them are ignored by the output stage.
// The sweep enable bit is stored and read back but drives nothing here.
// Software keeps it clear while pins steer modulation.
module pmc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] profile_pins,
	input wire logic [2:0] sdio_ramp_pins,
	output pmc_pkg::pmc_chan_s chan_out [4],
	output logic serial_single_bit
);
	// Configuration registers.
	logic [3:0] chan_enable; // Channels that take per-channel writes.
	logic [1:0] mod_level; // Global modulation level.
	logic [1:0] ramp_pins; // Ramp pin assignment.
	logic [2:0] pin_assignment_config; // Pin to channel routing.
	logic [1:0] mod_type_select [4]; // Per-channel modulation type.
	logic sweep_en [4]; // Per-channel sweep enable, stored only.
	logic [31:0] first_freq [4]; // Word zero for frequency.
	logic [13:0] first_phase [4]; // Word zero for phase.
	logic [9:0] first_amp [4]; // Word zero for amplitude.
	logic [31:0] prof [4][1:15]; // Profile words 1 to 15.
	// Pin synchronisers.
	logic [3:0] pin_meta; // First stage, read only by the second.
	logic [3:0] pin_sync; // Resampled profile pins.
	logic [2:0] sdio_meta; // First stage, read only by the second.
	logic [2:0] sdio_sync; // Resampled ramp lines.
	// Decode results.
	logic [3:0] next_idx [4]; // Selected profile index per channel.
	logic next_ren [4]; // Ramp pin assigned per channel.
	logic next_rdn [4]; // Ramp direction per channel.
	logic [1:0] pair_a; // First channel of a pair.
	logic [1:0] pair_b; // Second channel of a pair.
	logic pair_ok; // Pair code is a listed one.
	logic [1:0] solo; // Single channel for eight and sixteen levels.
	// Bus decode.
	logic [5:0] ridx; // Register index from the address.
	logic mapped; // Address hits a register.
	logic is_prof; // Address hits a profile word.
	logic [3:0] pslot; // Profile slot from the address.
	logic wr_en; // Write takes effect this edge.
	logic [1:0] rd_ch; // Channel shown on per-channel reads.
	logic [31:0] next_rdata; // Read mux result.

	assign ridx = paddr[7:2];
	assign is_prof = (ridx >= pmc_pkg::IDX_PROFILE_FIRST) && (ridx <= pmc_pkg::IDX_PROFILE_LAST);
	assign pslot = 4'(ridx - pmc_pkg::IDX_PROFILE_FIRST + 6'h01);
	assign mapped = is_prof || (ridx == pmc_pkg::IDX_CHAN_SELECT)
		|| (ridx == pmc_pkg::IDX_GLOBAL_FUNC) || (ridx == pmc_pkg::IDX_CHAN_FUNC)
		|| (ridx == pmc_pkg::IDX_FIRST_FREQ) || (ridx == pmc_pkg::IDX_FIRST_PHASE)
		|| (ridx == pmc_pkg::IDX_FIRST_AMP);
	// The slave never waits, so every access completes in its first access cycle.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && mapped;
	// Serial lines serve ramping only in this mode, so the port is held to one bit.
	assign serial_single_bit = (ramp_pins == pmc_pkg::RAMP_SDIO);

	// Reads of per-channel registers show the lowest enabled channel.
	always_comb begin
		if (chan_enable[0]) begin
			rd_ch = 2'h0;
		end else if (chan_enable[1]) begin
			rd_ch = 2'h1;
		end else if (chan_enable[2]) begin
			rd_ch = 2'h2;
		end else begin
			rd_ch = 2'h3;
		end
	end

	// Read data mux; reserved bits and unmapped addresses read as zero.
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (is_prof) begin
			next_rdata = prof[rd_ch][pslot];
		end else begin
			case (ridx)
				pmc_pkg::IDX_CHAN_SELECT: next_rdata[3:0] = chan_enable;
				pmc_pkg::IDX_GLOBAL_FUNC: begin
					next_rdata[pmc_pkg::GF_LEVEL_LSB +: 2] = mod_level;
					next_rdata[pmc_pkg::GF_RAMP_LSB +: 2] = ramp_pins;
					next_rdata[pmc_pkg::GF_PINCFG_LSB +: 3] = pin_assignment_config;
				end
				pmc_pkg::IDX_CHAN_FUNC: begin
					next_rdata[pmc_pkg::CF_TYPE_LSB +: 2] = mod_type_select[rd_ch];
					next_rdata[pmc_pkg::CF_SWEEP_BIT] = sweep_en[rd_ch];
				end
				pmc_pkg::IDX_FIRST_FREQ: next_rdata = first_freq[rd_ch];
				pmc_pkg::IDX_FIRST_PHASE: next_rdata[13:0] = first_phase[rd_ch];
				pmc_pkg::IDX_FIRST_AMP: next_rdata[9:0] = first_amp[rd_ch];
				default: next_rdata = 32'h0000_0000;
			endcase
		end
		if (chan_enable == 4'h0 && ridx != pmc_pkg::IDX_CHAN_SELECT
			&& ridx != pmc_pkg::IDX_GLOBAL_FUNC) begin
			next_rdata = 32'h0000_0000;
		end
	end

	// Read data is registered so it stands in the cycle after setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= (psel && !penable && !pwrite) ? next_rdata : prdata;
		end
	end

	// Global registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_enable <= pmc_pkg::CSR_EN_RESET;
			mod_level <= pmc_pkg::LVL_TWO;
			ramp_pins <= pmc_pkg::RAMP_NONE;
			pin_assignment_config <= 3'h0;
		end else if (wr_en && ridx == pmc_pkg::IDX_CHAN_SELECT) begin
			chan_enable <= pwdata[pmc_pkg::CSR_EN_LSB +: 4];
		end else if (wr_en && ridx == pmc_pkg::IDX_GLOBAL_FUNC) begin
			mod_level <= pwdata[pmc_pkg::GF_LEVEL_LSB +: 2];
			ramp_pins <= pwdata[pmc_pkg::GF_RAMP_LSB +: 2];
			pin_assignment_config <= pwdata[pmc_pkg::GF_PINCFG_LSB +: 3];
		end
	end

	// Per-channel registers; a write lands in every enabled channel at once.
	genvar g;
	generate
		for (g = 0; g < pmc_pkg::NCH; g++) begin : g_chan
			logic ch_wr; // This channel takes the write.
			logic [31:0] word; // Selected channel word.
			assign ch_wr = wr_en && chan_enable[g];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mod_type_select[g] <= pmc_pkg::TYPE_OFF;
					sweep_en[g] <= 1'b0;
					first_freq[g] <= pmc_pkg::WORD_RESET;
					first_phase[g] <= 14'h0000;
					first_amp[g] <= 10'h000;
				end else if (ch_wr) begin
					case (ridx)
						pmc_pkg::IDX_CHAN_FUNC: begin
							mod_type_select[g] <= pwdata[pmc_pkg::CF_TYPE_LSB +: 2];
							sweep_en[g] <= pwdata[pmc_pkg::CF_SWEEP_BIT];
						end
						pmc_pkg::IDX_FIRST_FREQ: first_freq[g] <= pwdata;
						pmc_pkg::IDX_FIRST_PHASE: first_phase[g] <= pwdata[13:0];
						pmc_pkg::IDX_FIRST_AMP: first_amp[g] <= pwdata[9:0];
						default: ;
					endcase
				end
			end

			// Profile words 1 to 15 of this channel.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					for (int k = 1; k < 16; k++) begin
						prof[g][k] <= pmc_pkg::WORD_RESET;
					end
				end else if (ch_wr && is_prof) begin
					prof[g][pslot] <= pwdata;
				end
			end

			// Index zero or a channel with modulation off falls back to the dedicated word.
			always_comb begin
				if (next_idx[g] == 4'h0) begin
					case (mod_type_select[g])
						pmc_pkg::TYPE_AMP: word = {first_amp[g], 22'h000000};
						pmc_pkg::TYPE_PHASE: word = {first_phase[g], 18'h00000};
						default: word = first_freq[g];
					endcase
				end else begin
					word = prof[g][next_idx[g]];
				end
			end

			// One register stage for every channel and type keeps the delays matched.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					chan_out[g] <= '0;
				end else begin
					chan_out[g].freq <= (mod_type_select[g] == pmc_pkg::TYPE_FREQ)
						? word : first_freq[g];
					chan_out[g].phase <= (mod_type_select[g] == pmc_pkg::TYPE_PHASE)
						? word[31:18] : first_phase[g];
					chan_out[g].amp <= (mod_type_select[g] == pmc_pkg::TYPE_AMP)
						? word[31:22] : first_amp[g];
					chan_out[g].ramp_en <= next_ren[g];
					chan_out[g].ramp_down <= next_rdn[g];
				end
			end
		end
	endgenerate

	// Pins come from outside, so each passes two flops before use.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
			sdio_meta <= 3'h0;
			sdio_sync <= 3'h0;
		end else begin
			pin_meta <= profile_pins;
			pin_sync <= pin_meta;
			sdio_meta <= sdio_ramp_pins;
			sdio_sync <= sdio_meta;
		end
	end

	// Channel pair for the paired modes; codes 110 and 111 are not listed.
	always_comb begin
		pair_ok = 1'b1;
		case (pin_assignment_config)
			3'h0: {pair_a, pair_b} = {2'h0, 2'h1};
			3'h1: {pair_a, pair_b} = {2'h0, 2'h2};
			3'h2: {pair_a, pair_b} = {2'h0, 2'h3};
			3'h3: {pair_a, pair_b} = {2'h1, 2'h2};
			3'h4: {pair_a, pair_b} = {2'h1, 2'h3};
			3'h5: {pair_a, pair_b} = {2'h2, 2'h3};
			default: begin
				{pair_a, pair_b} = {2'h0, 2'h1};
				pair_ok = 1'b0;
			end
		endcase
	end
	assign solo = pin_assignment_config[1:0];

	// Notes on the routing below.
	// Two-level without ramp gives each pin to its own channel.
	// Two-level with serial ramp lines routes the pins the same way.
	// Two-level with pins two and three on ramp serves one channel pair.
	// In that mode pins zero and one pick the words of the pair.
	// Four-level gives two pins to each channel of the chosen pair.
	// Eight-level gives pins zero to two to one channel.
	// Pin three then either idles or carries that channel's ramp.
	// Sixteen-level gives all four pins to one channel.
	// Only the low two routing bits pick the channel in solo modes.
	// The top routing bit is ignored there, as the assignment allows.
	// A ramp pin low asks for a ramp up and high for a ramp down.
	// Defaults at the top keep every path free of inferred latches.
	// The final loop forces word zero on channels with modulation off.
	// That override comes last so no earlier branch can defeat it.
	// Pin routing; pin zero is the most significant index bit.
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			next_idx[c] = 4'h0;
			next_ren[c] = 1'b0;
			next_rdn[c] = 1'b0;
		end
		case (mod_level)
			pmc_pkg::LVL_TWO: begin
				if (ramp_pins == pmc_pkg::RAMP_NONE || ramp_pins == pmc_pkg::RAMP_SDIO) begin
					for (int c = 0; c < 4; c++) begin
						next_idx[c] = {3'h0, pin_sync[c]};
					end
				end else if (ramp_pins == pmc_pkg::RAMP_PIN23 && pair_ok) begin
					next_idx[pair_a] = {3'h0, pin_sync[0]};
					next_idx[pair_b] = {3'h0, pin_sync[1]};
					next_ren[pair_a] = 1'b1;
					next_rdn[pair_a] = pin_sync[2];
					next_ren[pair_b] = 1'b1;
					next_rdn[pair_b] = pin_sync[3];
				end
			end
			pmc_pkg::LVL_FOUR: begin
				if ((ramp_pins == pmc_pkg::RAMP_NONE || ramp_pins == pmc_pkg::RAMP_SDIO)
					&& pair_ok) begin
					next_idx[pair_a] = {2'h0, pin_sync[0], pin_sync[1]};
					next_idx[pair_b] = {2'h0, pin_sync[2], pin_sync[3]};
				end
			end
			pmc_pkg::LVL_EIGHT: begin
				if (ramp_pins == pmc_pkg::RAMP_NONE || ramp_pins == pmc_pkg::RAMP_PIN3) begin
					next_idx[solo] = {1'b0, pin_sync[0], pin_sync[1], pin_sync[2]};
					next_ren[solo] = (ramp_pins == pmc_pkg::RAMP_PIN3);
					next_rdn[solo] = (ramp_pins == pmc_pkg::RAMP_PIN3) && pin_sync[3];
				end
			end
			pmc_pkg::LVL_SIXTEEN: begin
				if (ramp_pins == pmc_pkg::RAMP_NONE || ramp_pins == pmc_pkg::RAMP_SDIO) begin
					next_idx[solo] = {pin_sync[0], pin_sync[1], pin_sync[2], pin_sync[3]};
				end
			end
			default: ;
		endcase
		// Serial lines only steer the ramp and never touch the index.
		if (ramp_pins == pmc_pkg::RAMP_SDIO && mod_level != pmc_pkg::LVL_EIGHT) begin
			for (int c = 0; c < 4; c++) begin
				next_ren[c] = 1'b1;
				next_rdn[c] = sdio_sync[(c > 2) ? 2 : c];
			end
		end
		// A channel with modulation off always shows its dedicated words.
		for (int c = 0; c < 4; c++) begin
			if (mod_type_select[c] == pmc_pkg::TYPE_OFF) begin
				next_idx[c] = 4'h0;
			end
		end
	end
endmodule // pmc_top

// ===== pmc_pin_ctl.sv
// Model of the external controller that drives the profile and serial ramp pins.
`timescale 1ns/1ps
module pmc_pin_ctl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] want_pins,
	input wire logic [2:0] want_sdio,
	output logic [3:0] profile_pins,
	output logic [2:0] sdio_ramp_pins
);
	// Pins move only just after an edge, so the block sees clean steps to resample.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			profile_pins <= 4'h0;
			sdio_ramp_pins <= 3'h0;
		end else begin
			profile_pins <= want_pins;
			sdio_ramp_pins <= want_sdio;
		end
	end
endmodule // pmc_pin_ctl

// ===== pmc_props.sv
// Checker for the modulation control block, bound to its top module.
`timescale 1ns/1ps
module pmc_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] profile_pins,
	input wire logic [2:0] sdio_ramp_pins,
	input wire pmc_pkg::pmc_chan_s chan_out [4],
	input wire logic serial_single_bit
);
	logic [1:0] lvl, ramp; // Own copy of the level and ramp fields.
	logic [2:0] pcfg; // Own copy of the pin configuration.
	logic [3:0] cfg_age, pin_age, hi_age, sd_age; // Saturating quiet counters.
	logic [3:0] p_q;
	logic [2:0] s_q;
	logic acc, bad;
	pmc_pkg::pmc_chan_s [3:0] all; // Packed view, since $stable wants a packed value.
	assign all = {chan_out[3], chan_out[2], chan_out[1], chan_out[0]};
	assign acc = psel && penable;
	assign bad = !(paddr[7:2] inside {6'h00, 6'h01, 6'h03, [6'h04:6'h06], [6'h0A:6'h18]});
	// Mirror the global fields so expectations never lean on the design's own state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{pcfg, ramp, lvl} <= 7'h00;
		end else if (acc && pwrite && paddr[7:2] == pmc_pkg::IDX_GLOBAL_FUNC) begin
			{pcfg, ramp, lvl} <= pwdata[14:8];
		end
	end
	// Ages count edges since the last write or pin movement; the pipeline needs three.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cfg_age, pin_age, hi_age, sd_age} <= 16'h0000;
			{p_q, s_q} <= 7'h00;
		end else begin
			p_q <= profile_pins;
			s_q <= sdio_ramp_pins;
			cfg_age <= (acc && pwrite) ? 4'h0 : cfg_age + {3'h0, cfg_age != 4'hF};
			pin_age <= (profile_pins != p_q) ? 4'h0 : pin_age + {3'h0, pin_age != 4'hF};
			hi_age <= (profile_pins[3:1] != p_q[3:1]) ? 4'h0 : hi_age + {3'h0, hi_age != 4'hF};
			sd_age <= (sdio_ramp_pins != s_q) ? 4'h0 : sd_age + {3'h0, sd_age != 4'hF};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_unmapped_err: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (acc && !bad |-> pready && !pslverr)
		else $error("mapped access refused");
	chk_single_bit: assert property (serial_single_bit == (ramp == 2'h3))
		else $error("single-bit flag wrong");
	chk_outputs_hold: assert property (cfg_age > 4'h3 && pin_age > 4'h3 && sd_age > 4'h3
		|-> $stable(all))
		else $error("outputs moved while inputs quiet");
	chk_two_level_iso: assert property (lvl == 2'h0 && ramp == 2'h0 && cfg_age > 4'h3
		&& hi_age > 4'h3 |-> $stable(all[3:1])) else $error("pin zero reached other channels");
	chk_ramp_pin_dir: assert property (lvl == 2'h0 && ramp == 2'h1 && pcfg == 3'h0
		&& cfg_age > 4'h3 |-> chan_out[0].ramp_en && chan_out[0].ramp_down == $past(profile_pins[2], 3)
		&& chan_out[1].ramp_down == $past(profile_pins[3], 3)) else $error("ramp pin direction");
	chk_sdio_ramp: assert property (ramp == 2'h3 && lvl != 2'h2 && cfg_age > 4'h3
		|-> chan_out[0].ramp_en && chan_out[0].ramp_down == $past(sdio_ramp_pins[0], 3)
		&& chan_out[3].ramp_down == $past(sdio_ramp_pins[2], 3)) else $error("serial ramp");
	chk_sdio_no_word: assert property (ramp == 2'h3 && cfg_age > 4'h3 && pin_age > 4'h3
		|-> $stable(chan_out[0].freq)) else $error("serial line selected a word");
	cover property (lvl == 2'h3 && cfg_age > 4'h3);
	cover property (ramp == 2'h3 && sd_age == 4'h0);
	cover property (acc && bad);
endmodule // pmc_props

bind pmc_top pmc_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .profile_pins(profile_pins), .sdio_ramp_pins(sdio_ramp_pins),
	.chan_out(chan_out), .serial_single_bit(serial_single_bit));

// ===== tb.sv
// Self-checking testbench for the modulation control block.
`timescale 1ns/1ps
module tb;
	localparam logic [31:0] f0 = 32'h0123_4567; // Dedicated frequency word.
	localparam logic [13:0] ph0 = 14'h1ABC; // Dedicated phase word.
	localparam logic [9:0] am0 = 10'h2F3; // Dedicated amplitude word.
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serial_single_bit, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, w1;
	logic [3:0] want_pins, profile_pins;
	logic [2:0] want_sdio, sdio_ramp_pins;
	pmc_pkg::pmc_chan_s chan_out [4];
	int n_mismatch, comparisons, cycles;
	pmc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .profile_pins(profile_pins), .sdio_ramp_pins(sdio_ramp_pins),
		.chan_out(chan_out), .serial_single_bit(serial_single_bit));
	pmc_pin_ctl ctl_u (.pclk(pclk), .presetn(presetn), .want_pins(want_pins),
		.want_sdio(want_sdio), .profile_pins(profile_pins), .sdio_ramp_pins(sdio_ramp_pins));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// Profile word k carries k in its top nibble, so phase and amplitude slices differ.
	function automatic logic [31:0] pw(input int k);
		return (k == 0) ? f0 : {k[3:0], 28'h05A_5A5A};
	endfunction
	assign w1 = pw(1);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Global field write: pin configuration, ramp field, level field.
	task automatic glb(input logic [2:0] c, input logic [1:0] r, input logic [1:0] l);
		apb(1'b1, pmc_pkg::IDX_GLOBAL_FUNC, {17'h0_0000, c, r, l, 8'h00});
	endtask
	// Channels in on get type t, the rest are switched off; sweep stays clear.
	task automatic typ(input logic [3:0] on, input logic [1:0] t);
		apb(1'b1, pmc_pkg::IDX_CHAN_SELECT, {28'h0, on});
		apb(1'b1, pmc_pkg::IDX_CHAN_FUNC, {8'h00, t, 22'h0});
		apb(1'b1, pmc_pkg::IDX_CHAN_SELECT, {28'h0, ~on});
		apb(1'b1, pmc_pkg::IDX_CHAN_FUNC, 32'h0);
		apb(1'b1, pmc_pkg::IDX_CHAN_SELECT, 32'hF);
	endtask
	// Waiting six edges covers the controller plus the fixed three-edge pin pipeline.
	task automatic pins(input logic [3:0] p, input logic [2:0] s);
		want_pins <= p;
		want_sdio <= s;
		repeat (6) @(posedge pclk);
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// The whole run needs about 480 cycles; a hang is cut off well beyond that.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, want_pins, want_sdio} = 50'h0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, pmc_pkg::IDX_FIRST_FREQ, f0);
		apb(1'b1, pmc_pkg::IDX_FIRST_PHASE, {18'h0, ph0});
		apb(1'b1, pmc_pkg::IDX_FIRST_AMP, {22'h0, am0});
		for (int k = 1; k < 16; k++) apb(1'b1, pmc_pkg::IDX_PROFILE_FIRST + 6'(k - 1), pw(k));
		apb(1'b0, pmc_pkg::IDX_PROFILE_LAST, 32'h0);
		chk("word15", pw(15), rd);
		apb(1'b0, 6'h07, 32'h0);
		chk("refused", 32'h1, {31'h0, err});
		typ(4'h1, 2'h2);
		glb(3'h5, 2'h0, 2'h0);
		pins(4'hF, 3'h0);
		chk("ch0_freq", w1, chan_out[0].freq);
		chk("ch1_freq", f0, chan_out[1].freq);
		typ(4'hF, 2'h2);
		for (int n = 0; n < 4; n++) begin
			pins(4'(1 << n), 3'h0);
			for (int m = 0; m < 4; m++) chk("two", (m == n) ? w1 : f0, chan_out[m].freq);
		end
		typ(4'hF, 2'h3);
		pins(4'h1, 3'h0);
		chk("phase", {18'h0, w1[31:18]}, chan_out[0].phase);
		chk("phase_ch1", {18'h0, ph0}, chan_out[1].phase);
		typ(4'hF, 2'h1);
		pins(4'h1, 3'h0);
		chk("amp", {22'h0, w1[31:22]}, chan_out[0].amp);
		chk("amp_ch1", {22'h0, am0}, chan_out[1].amp);
		typ(4'h8, 2'h2);
		glb(3'h3, 2'h0, 2'h3);
		for (int i = 0; i < 16; i++) begin
			pins({i[0], i[1], i[2], i[3]}, 3'h0);
			chk("sixteen", pw(i), chan_out[3].freq);
		end
		typ(4'h2, 2'h2);
		glb(3'h5, 2'h0, 2'h2);
		for (int i = 0; i < 8; i++) begin
			pins({1'b1, i[0], i[1], i[2]}, 3'h0);
			chk("eight", pw(i), chan_out[1].freq);
		end
		typ(4'h9, 2'h2);
		glb(3'h2, 2'h0, 2'h1);
		pins(4'hB, 3'h0);
		chk("four_ch0", pw(3), chan_out[0].freq);
		chk("four_ch3", w1, chan_out[3].freq);
		glb(3'h6, 2'h0, 2'h1);
		pins(4'hF, 3'h0);
		chk("unlisted", f0, chan_out[0].freq);
		typ(4'h3, 2'h2);
		glb(3'h0, 2'h1, 2'h0);
		pins(4'h4, 3'h0);
		chk("ramp_ch0", 32'h3, {chan_out[0].ramp_en, chan_out[0].ramp_down});
		chk("ramp_ch1", 32'h2, {chan_out[1].ramp_en, chan_out[1].ramp_down});
		typ(4'h1, 2'h2);
		glb(3'h0, 2'h2, 2'h2);
		pins(4'hF, 3'h0);
		chk("p3_word", pw(7), chan_out[0].freq);
		chk("p3_ramp", 32'h3, {chan_out[0].ramp_en, chan_out[0].ramp_down});
		typ(4'hF, 2'h2);
		glb(3'h0, 2'h3, 2'h0);
		for (int s = 2; s < 6; s += 3) begin
			pins(4'h0, 3'(s));
			chk("single", 32'h1, {31'h0, serial_single_bit});
			chk("sd_ch1", {1'b1, s[1]}, {chan_out[1].ramp_en, chan_out[1].ramp_down});
			chk("sd_ch3", {1'b1, s[2]}, {chan_out[3].ramp_en, chan_out[3].ramp_down});
			chk("sd_word", f0, chan_out[0].freq);
		end
		finish_test();
	end
endmodule // tb
